// ==== common/uls_consts.svh ====
// offsets, field positions, reset values and timing counts for the line status block
// assumes a byte-wide register bus addressed by a 3-bit offset, divisor access low
`ifndef ULS_CONSTS_SVH
`define ULS_CONSTS_SVH
`define ULS_OFS_BUF 3'h0
`define ULS_OFS_MASK 3'h1
`define ULS_OFS_IDENT 3'h2
`define ULS_OFS_QCTL 3'h2
`define ULS_OFS_LCOND 3'h5
`define ULS_OFS_MSTAT 3'h6
`define ULS_OFS_STORE 3'h7
`define ULS_LC_READY 0
`define ULS_LC_OVERRUN 1
`define ULS_LC_PARITY 2
`define ULS_LC_FRAMING 3
`define ULS_LC_BREAK 4
`define ULS_LC_THE 5
`define ULS_LC_IDLE 6
`define ULS_LC_QERR 7
`define ULS_MASK_RX 0
`define ULS_MASK_TX 1
`define ULS_MASK_LINE 2
`define ULS_MASK_MODEM 3
`define ULS_QC_ENABLE 0
`define ULS_QC_TRIG_LO 6
`define ULS_ID_NONE 4'h1
`define ULS_ID_LINE 4'h6
`define ULS_ID_RXDATA 4'h4
`define ULS_ID_TIMEOUT 4'hc
`define ULS_ID_THE 4'h2
`define ULS_ID_MODEM 4'h0
`define ULS_MASK_RESET 8'h00
`define ULS_STORE_RESET 8'h00
`define ULS_QDEPTH 16
`define ULS_TRIG_1 5'h01
`define ULS_TRIG_4 5'h04
`define ULS_TRIG_8 5'h08
`define ULS_TRIG_14 5'h0e
`define ULS_TIMEOUT_CHARS 3'h4
`endif

// ==== common/uls_pkg.sv ====
// types for the line status and interrupt block
// assumes uls_consts.svh supplies the numbers
package uls_pkg;
	typedef struct packed {
		logic [7:0] data;
		logic parity_err;
		logic framing_err;
		logic brk;
	} uls_rx_char_t;
	typedef struct packed {
		logic cs;
		logic rd;
		logic wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} uls_bus_t;
	typedef enum logic [2:0] {
		SRC_NONE = 3'b000,
		SRC_LINE = 3'b001,
		SRC_RXDATA = 3'b010,
		SRC_TIMEOUT = 3'b011,
		SRC_THE = 3'b100,
		SRC_MODEM = 3'b101
	} uls_src_t;
endpackage

// ==== rtl/uls_line_status.sv ====
// line status, interrupt identity, interrupt mask and scratch byte for one channel
// assumes receiver and transmitter logic report events as one-cycle pulses; modem changes arrive as a held level
`include "uls_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module uls_line_status
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire uls_pkg::uls_bus_t bus,
	input wire logic queue_mode_enable,
	input wire logic [1:0] trigger_sel,
	input wire logic rx_char_valid,
	input wire uls_pkg::uls_rx_char_t rx_char,
	input wire logic rx_break_end,
	input wire logic char_time_tick,
	input wire logic tx_load_shifter,
	input wire logic tx_shifter_busy,
	input wire logic [3:0] modem_change,
	output logic [7:0] rdata,
	output logic irq_output,
	output logic [7:0] rx_data_out
);
	localparam int DW = 5;
	uls_pkg::uls_rx_char_t queue_mem [0:`ULS_QDEPTH-1];
	logic [3:0] rd_ptr_r, wr_ptr_r;
	logic [DW-1:0] count_r;
	logic overrun_r, parity_r, framing_r, break_r;
	logic tx_held_r;
	logic [4:0] tx_count_r;
	logic [7:0] irq_mask_reg;
	logic [7:0] general_byte_store;
	logic [4:0] err_tags_r;
	logic rx_blocked_r;
	logic [2:0] idle_chars_r;
	logic timeout_r;
	logic the_irq_r;
	uls_pkg::uls_src_t frozen_r;
	logic frozen_valid_r;
	logic [7:0] rdata_r;
	logic irq_r;
	logic rd_buf, rd_lcond, rd_ident, rd_mstat, wr_hold, wr_mask, wr_store;
	logic accept, push, pop, qfull, tag_push, tag_pop;
	logic head_err;
	uls_pkg::uls_rx_char_t head;
	logic [DW-1:0] trig;
	logic rx_ready, tx_empty, tx_idle, qerr;
	logic line_pend, data_pend, to_pend, the_pend, modem_pend;
	uls_pkg::uls_src_t top_src;
	logic [3:0] ident_code;
	logic [7:0] ident_byte, lcond_byte, rd_nxt;

	// decode: reads and writes are level strobes, active on every cycle the bus holds them
	always_comb
	begin
		rd_buf = 1'b0;
		rd_lcond = 1'b0;
		rd_ident = 1'b0;
		rd_mstat = 1'b0;
		wr_hold = 1'b0;
		wr_mask = 1'b0;
		wr_store = 1'b0;
		if (bus.cs && bus.rd && bus.addr == `ULS_OFS_BUF)
			rd_buf = 1'b1;
		else if (bus.cs && bus.rd && bus.addr == `ULS_OFS_LCOND)
			rd_lcond = 1'b1;
		else if (bus.cs && bus.rd && bus.addr == `ULS_OFS_IDENT)
			rd_ident = 1'b1;
		else if (bus.cs && bus.rd && bus.addr == `ULS_OFS_MSTAT)
			rd_mstat = 1'b1;
		else if (bus.cs && bus.wr && bus.addr == `ULS_OFS_BUF)
			wr_hold = 1'b1;
		else if (bus.cs && bus.wr && bus.addr == `ULS_OFS_MASK)
			wr_mask = 1'b1;
		else if (bus.cs && bus.wr && bus.addr == `ULS_OFS_STORE)
			wr_store = 1'b1;
		// writes to the status offset fall through and do nothing
	end

	// receive queue; character mode uses a depth of one
	always_comb
	begin
		qfull = queue_mode_enable ? (count_r == DW'(`ULS_QDEPTH)) : (count_r != '0);
		accept = rx_char_valid && !rx_blocked_r;
		push = accept && (!qfull || !queue_mode_enable);
		pop = rd_buf && (count_r != '0);
		head = queue_mem[rd_ptr_r];
		head_err = head.parity_err || head.framing_err || head.brk;
		tag_push = push && (rx_char.parity_err || rx_char.framing_err || rx_char.brk);
		tag_pop = pop && head_err;
		rx_ready = (count_r != '0);
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_ptr_r <= 4'h0;
			wr_ptr_r <= 4'h0;
			count_r <= '0;
		end
		else if (clk_en)
		begin
			if (push && queue_mode_enable)
			begin
				queue_mem[wr_ptr_r] <= rx_char;
				wr_ptr_r <= wr_ptr_r + 4'h1;
			end
			else if (push)
			begin
				// character mode overwrites the lone slot, losing the old one
				queue_mem[rd_ptr_r] <= rx_char;
			end
			if (pop && queue_mode_enable)
				rd_ptr_r <= rd_ptr_r + 4'h1;
			if (queue_mode_enable)
				count_r <= count_r + DW'(push) - DW'(pop);
			else if (push)
				count_r <= DW'(1);
			else if (pop)
				count_r <= '0;
		end
	end

	// break lockout: one zero character, then wait for the line to recover
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rx_blocked_r <= 1'b0;
		else if (clk_en)
		begin
			// a fresh break beats a release in the same cycle
			if (accept && rx_char.brk)
				rx_blocked_r <= 1'b1;
			else if (rx_break_end)
				rx_blocked_r <= 1'b0;
		end
	end

	// sticky line flags; a new event beats the clearing read, except the queued-mode tag flags, which a read or pop clears
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			overrun_r <= 1'b0;
			parity_r <= 1'b0;
			framing_r <= 1'b0;
			break_r <= 1'b0;
		end
		else if (clk_en)
		begin
			if (accept && qfull)
				overrun_r <= 1'b1;
			else if (rd_lcond)
				overrun_r <= 1'b0;
			if (queue_mode_enable)
			begin
				// queued mode shows the head character's tags
				if (pop || rd_lcond)
				begin
					parity_r <= 1'b0;
					framing_r <= 1'b0;
					break_r <= 1'b0;
				end
				else if (rx_ready)
				begin
					parity_r <= parity_r | head.parity_err;
					framing_r <= framing_r | head.framing_err;
					break_r <= break_r | head.brk;
				end
			end
			else
			begin
				if (push && rx_char.parity_err)
					parity_r <= 1'b1;
				else if (rd_lcond)
					parity_r <= 1'b0;
				if (push && rx_char.framing_err)
					framing_r <= 1'b1;
				else if (rd_lcond)
					framing_r <= 1'b0;
				if (push && rx_char.brk)
					break_r <= 1'b1;
				else if (rd_lcond)
					break_r <= 1'b0;
			end
		end
	end

	// count of tagged characters still queued
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			err_tags_r <= 5'h00;
		else if (clk_en)
			err_tags_r <= err_tags_r + 5'(tag_push && queue_mode_enable) - 5'(tag_pop && queue_mode_enable);
	end
	// summary stays up while a tag remains, so a status read cannot drop it early
	// five bits: a full queue of sixteen tagged characters must not wrap to zero
	assign qerr = queue_mode_enable && (err_tags_r != 5'h00);

	// transmit side: holding stage or queue occupancy
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_held_r <= 1'b0;
			tx_count_r <= 5'h00;
		end
		else if (clk_en)
		begin
			if (wr_hold)
				tx_held_r <= 1'b1;
			else if (tx_load_shifter && (tx_count_r <= 5'h01))
				tx_held_r <= 1'b0;
			// counts up to the full sixteen so the last queued byte keeps the flag low
			if (!queue_mode_enable)
				tx_count_r <= 5'h00;
			else if (wr_hold && !tx_load_shifter && tx_count_r != 5'(`ULS_QDEPTH))
				tx_count_r <= tx_count_r + 5'h01;
			else if (!wr_hold && tx_load_shifter && tx_count_r != 5'h00)
				tx_count_r <= tx_count_r - 5'h01;
		end
	end
	assign tx_empty = !tx_held_r;
	assign tx_idle = tx_empty && !tx_shifter_busy;

	// character timeout: count idle character times while data is queued
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			idle_chars_r <= 3'h0;
			timeout_r <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!queue_mode_enable || !rx_ready || push || pop)
			begin
				idle_chars_r <= 3'h0;
				timeout_r <= 1'b0;
			end
			else if (char_time_tick && idle_chars_r != `ULS_TIMEOUT_CHARS)
				idle_chars_r <= idle_chars_r + 3'h1;
			else if (idle_chars_r == `ULS_TIMEOUT_CHARS)
				timeout_r <= 1'b1;
		end
	end

	// holding-empty interrupt: armed on empty, dropped by identity read or write
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			the_irq_r <= 1'b0;
		else if (clk_en)
		begin
			if (tx_load_shifter && (tx_count_r <= 5'h01) && !wr_hold)
				the_irq_r <= 1'b1;
			else if (wr_hold || (rd_ident && top_src == uls_pkg::SRC_THE))
				the_irq_r <= 1'b0;
			else if (wr_mask && bus.wdata[`ULS_MASK_TX] && !irq_mask_reg[`ULS_MASK_TX] && tx_empty)
				the_irq_r <= 1'b1;
		end
	end

	always_comb
	begin
		case (trigger_sel)
			2'b00: trig = `ULS_TRIG_1;
			2'b01: trig = `ULS_TRIG_4;
			2'b10: trig = `ULS_TRIG_8;
			default: trig = `ULS_TRIG_14;
		endcase
		line_pend = irq_mask_reg[`ULS_MASK_LINE] && (overrun_r || parity_r || framing_r || break_r);
		if (queue_mode_enable)
			data_pend = irq_mask_reg[`ULS_MASK_RX] && (count_r >= trig);
		else
			data_pend = irq_mask_reg[`ULS_MASK_RX] && rx_ready;
		to_pend = irq_mask_reg[`ULS_MASK_RX] && timeout_r;
		the_pend = irq_mask_reg[`ULS_MASK_TX] && the_irq_r;
		modem_pend = irq_mask_reg[`ULS_MASK_MODEM] && (modem_change != 4'h0);
		if (line_pend)
			top_src = uls_pkg::SRC_LINE;
		else if (data_pend)
			top_src = uls_pkg::SRC_RXDATA;
		else if (to_pend)
			top_src = uls_pkg::SRC_TIMEOUT;
		else if (the_pend)
			top_src = uls_pkg::SRC_THE;
		else if (modem_pend)
			top_src = uls_pkg::SRC_MODEM;
		else
			top_src = uls_pkg::SRC_NONE;
	end

	// freeze: identity read pins any source but the holding-empty one until its own clear event
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			frozen_r <= uls_pkg::SRC_NONE;
			frozen_valid_r <= 1'b0;
		end
		else if (clk_en)
		begin
			if (rd_ident && !frozen_valid_r && top_src != uls_pkg::SRC_NONE && top_src != uls_pkg::SRC_THE)
			begin
				frozen_r <= top_src;
				frozen_valid_r <= 1'b1;
			end
			else if (frozen_valid_r)
			begin
				case (frozen_r)
					uls_pkg::SRC_LINE: frozen_valid_r <= !rd_lcond && line_pend;
					uls_pkg::SRC_RXDATA: frozen_valid_r <= !rd_buf && data_pend;
					uls_pkg::SRC_TIMEOUT: frozen_valid_r <= !rd_buf && to_pend;
					uls_pkg::SRC_MODEM: frozen_valid_r <= !rd_mstat && modem_pend;
					default: frozen_valid_r <= 1'b0;
				endcase
			end
		end
	end

	always_comb
	begin
		case (frozen_valid_r ? frozen_r : top_src)
			uls_pkg::SRC_LINE: ident_code = `ULS_ID_LINE;
			uls_pkg::SRC_RXDATA: ident_code = `ULS_ID_RXDATA;
			uls_pkg::SRC_TIMEOUT: ident_code = `ULS_ID_TIMEOUT;
			uls_pkg::SRC_THE: ident_code = `ULS_ID_THE;
			uls_pkg::SRC_MODEM: ident_code = `ULS_ID_MODEM;
			default: ident_code = `ULS_ID_NONE;
		endcase
		ident_byte = {{2{queue_mode_enable}}, 2'b00, ident_code};
		lcond_byte = {qerr, tx_idle, tx_empty, break_r, framing_r, parity_r, overrun_r, rx_ready};
		if (bus.addr == `ULS_OFS_BUF)
			rd_nxt = head.data;
		else if (bus.addr == `ULS_OFS_MASK)
			rd_nxt = {4'h0, irq_mask_reg[3:0]};
		else if (bus.addr == `ULS_OFS_IDENT)
			rd_nxt = ident_byte;
		else if (bus.addr == `ULS_OFS_LCOND)
			rd_nxt = lcond_byte;
		else if (bus.addr == `ULS_OFS_STORE)
			rd_nxt = general_byte_store;
		else
			rd_nxt = 8'h00;
	end

	// mask and scratch; only the low nibble of the mask is kept
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_mask_reg <= `ULS_MASK_RESET;
			general_byte_store <= `ULS_STORE_RESET;
		end
		else if (clk_en)
		begin
			if (wr_mask)
				irq_mask_reg <= {4'h0, bus.wdata[3:0]};
			if (wr_store)
				general_byte_store <= bus.wdata;
		end
	end

	// registered outputs: read data one cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata_r <= 8'h00;
			irq_r <= 1'b0;
			rx_data_out <= 8'h00;
		end
		else if (clk_en)
		begin
			if (bus.cs && bus.rd)
				rdata_r <= rd_nxt;
			irq_r <= (top_src != uls_pkg::SRC_NONE);
			if (pop)
				rx_data_out <= head.data;
		end
	end
	assign rdata = rdata_r;
	assign irq_output = irq_r;
endmodule
`default_nettype wire

// ==== test/uls_event_source.sv ====
// receiver, transmitter and modem side feeding events into the line status block
// assumes the bench calls its tasks; every pulse lasts one ref_clk cycle
`timescale 1ns/100ps
`default_nettype none
module uls_event_source
(
	input wire logic ref_clk,
	output uls_pkg::uls_rx_char_t rx_char,
	output logic rx_char_valid,
	output logic rx_break_end,
	output logic char_time_tick,
	output logic tx_load_shifter,
	output logic tx_shifter_busy,
	output logic [3:0] modem_change
);
	initial
	begin
		rx_char = '0;
		{rx_char_valid, rx_break_end, char_time_tick, tx_load_shifter, tx_shifter_busy} = 5'h00;
		modem_change = 4'h0;
	end
	// tag order parity, framing, break
	task automatic send(input logic [7:0] d, input logic [2:0] tag);
		@(posedge ref_clk);
		rx_char <= {(tag[0] ? 8'h00 : d), tag};
		rx_char_valid <= 1'b1;
		@(posedge ref_clk);
		rx_char_valid <= 1'b0;
		// released data must not look valid
		rx_char <= ~rx_char;
	endtask
	// 0 break end, 1 tick, 2 load shifter, 3 shifter drained
	task automatic pulse(input int k);
		@(posedge ref_clk);
		rx_break_end <= (k == 0);
		char_time_tick <= (k == 1);
		tx_load_shifter <= (k == 2);
		if (k >= 2)
			tx_shifter_busy <= (k == 2);
		@(posedge ref_clk);
		{rx_break_end, char_time_tick, tx_load_shifter} <= 3'h0;
	endtask
	task automatic modem(input logic [3:0] v);
		@(posedge ref_clk);
		modem_change <= v;
	endtask
endmodule
`default_nettype wire

// ==== test/uls_line_status_bench.sv ====
// self-checking bench for the line status block
// assumes uls_event_source plays receiver, transmitter and modem side
`include "uls_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module uls_line_status_bench;
	logic ref_clk = 1'b0;
	logic rst_n, clk_en, qm, irq_output, rx_char_valid, rx_break_end, char_time_tick, tx_load_shifter, tx_shifter_busy;
	logic [1:0] trig;
	logic [3:0] modem_change;
	logic [7:0] rdata, rx_data_out;
	uls_pkg::uls_bus_t bus;
	uls_pkg::uls_rx_char_t rx_char;
	int errors = 0;
	int comparisons = 0;
	int i, t;
	int lv [4] = '{`ULS_TRIG_1, `ULS_TRIG_4, `ULS_TRIG_8, `ULS_TRIG_14};
	always #4 ref_clk = ~ref_clk;
	uls_event_source ev (.ref_clk(ref_clk), .rx_char(rx_char), .rx_char_valid(rx_char_valid),
		.rx_break_end(rx_break_end), .char_time_tick(char_time_tick), .tx_load_shifter(tx_load_shifter),
		.tx_shifter_busy(tx_shifter_busy), .modem_change(modem_change));
	uls_line_status dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .bus(bus), .queue_mode_enable(qm),
		.trigger_sel(trig), .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_break_end(rx_break_end),
		.char_time_tick(char_time_tick), .tx_load_shifter(tx_load_shifter), .tx_shifter_busy(tx_shifter_busy),
		.modem_change(modem_change), .rdata(rdata), .irq_output(irq_output), .rx_data_out(rx_data_out));
	task automatic end_of_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// one held cycle per access, since reads clear on every held cycle
	task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus <= '{cs: 1'b1, rd: !w, wr: w, addr: a, wdata: d};
		@(posedge ref_clk);
		bus <= '0;
		#1;
	endtask
	task automatic rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		chk("rdata", e, rdata & m);
	endtask
	task automatic irq_is(input logic e);
		repeat (2) @(posedge ref_clk);
		#1;
		chk("irq", {7'h0, e}, {7'h0, irq_output});
	endtask
	initial
	begin
		#100000;
		errors++;
		end_of_test();
	end
	initial
	begin
		{rst_n, clk_en, qm, trig, bus} = '0;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		clk_en <= 1'b1;
		rchk(`ULS_OFS_MASK, 8'hff, `ULS_MASK_RESET);
		rchk(`ULS_OFS_STORE, 8'hff, `ULS_STORE_RESET);
		rchk(`ULS_OFS_IDENT, 8'hff, 8'h01);
		acc(1'b1, `ULS_OFS_STORE, 8'ha5);
		rchk(`ULS_OFS_STORE, 8'hff, 8'ha5);
		// a write with the clock enable low must leave the byte alone
		@(posedge ref_clk);
		clk_en <= 1'b0;
		acc(1'b1, `ULS_OFS_STORE, 8'h3c);
		@(posedge ref_clk);
		clk_en <= 1'b1;
		rchk(`ULS_OFS_STORE, 8'hff, 8'ha5);
		acc(1'b1, `ULS_OFS_MASK, 8'hf4);
		rchk(`ULS_OFS_MASK, 8'hff, 8'h04);
		ev.send(8'h3c, 3'b100);
		irq_is(1'b1);
		rchk(`ULS_OFS_IDENT, 8'hff, 8'h06);
		ev.send(8'h5a, 3'b010);
		rchk(`ULS_OFS_LCOND, 8'h9f, 8'h0f);
		rchk(`ULS_OFS_LCOND, 8'h9f, 8'h01);
		irq_is(1'b0);
		acc(1'b0, `ULS_OFS_BUF, 8'h00);
		chk("rx", 8'h5a, rx_data_out);
		ev.send(8'h77, 3'b001);
		rchk(`ULS_OFS_LCOND, 8'h9f, 8'h11);
		acc(1'b0, `ULS_OFS_BUF, 8'h00);
		ev.send(8'h66, 3'b000);
		rchk(`ULS_OFS_LCOND, 8'h9f, 8'h00);
		chk("rx", 8'h00, rx_data_out);
		ev.pulse(0);
		ev.send(8'h66, 3'b000);
		acc(1'b1, `ULS_OFS_MASK, 8'h01);
		irq_is(1'b1);
		rchk(`ULS_OFS_IDENT, 8'hff, 8'h04);
		acc(1'b0, `ULS_OFS_BUF, 8'h00);
		chk("rx", 8'h66, rx_data_out);
		chk("rdata", 8'h66, rdata);
		irq_is(1'b0);
		acc(1'b1, `ULS_OFS_MASK, 8'h02);
		acc(1'b1, `ULS_OFS_BUF, 8'h41);
		rchk(`ULS_OFS_LCOND, 8'h20, 8'h00);
		ev.pulse(2);
		rchk(`ULS_OFS_LCOND, 8'h60, 8'h20);
		irq_is(1'b1);
		rchk(`ULS_OFS_IDENT, 8'hff, 8'h02);
		irq_is(1'b0);
		ev.pulse(3);
		rchk(`ULS_OFS_LCOND, 8'h60, 8'h60);
		acc(1'b1, `ULS_OFS_MASK, 8'h08);
		ev.modem(4'h2);
		irq_is(1'b1);
		rchk(`ULS_OFS_IDENT, 8'hff, 8'h00);
		acc(1'b0, `ULS_OFS_MSTAT, 8'h00);
		acc(1'b1, `ULS_OFS_MASK, 8'h00);
		irq_is(1'b0);
		rchk(`ULS_OFS_IDENT, 8'hff, 8'h01);
		ev.modem(4'h0);
		qm <= 1'b1;
		acc(1'b1, `ULS_OFS_MASK, 8'h01);
		for (t = 0; t < 4; t++)
		begin
			@(posedge ref_clk);
			trig <= t[1:0];
			for (i = 1; i < lv[t]; i++)
				ev.send(i[7:0], 3'b000);
			irq_is(1'b0);
			ev.send(lv[t][7:0], 3'b000);
			irq_is(1'b1);
			rchk(`ULS_OFS_IDENT, 8'hff, 8'hc4);
			for (i = 1; i <= lv[t]; i++)
			begin
				acc(1'b0, `ULS_OFS_BUF, 8'h00);
				chk("rx", i[7:0], rx_data_out);
				if (i == 1)
					irq_is(1'b0);
			end
		end
		ev.send(8'h99, 3'b000);
		repeat (3) ev.pulse(1);
		rchk(`ULS_OFS_IDENT, 8'hff, 8'hc1);
		repeat (2) ev.pulse(1);
		rchk(`ULS_OFS_IDENT, 8'hff, 8'hcc);
		acc(1'b0, `ULS_OFS_BUF, 8'h00);
		irq_is(1'b0);
		ev.send(8'h21, 3'b000);
		ev.send(8'h22, 3'b100);
		rchk(`ULS_OFS_LCOND, 8'h9f, 8'h81);
		acc(1'b0, `ULS_OFS_BUF, 8'h00);
		rchk(`ULS_OFS_LCOND, 8'h9f, 8'h85);
		acc(1'b0, `ULS_OFS_BUF, 8'h00);
		rchk(`ULS_OFS_LCOND, 8'h9f, 8'h00);
		for (i = 0; i <= `ULS_QDEPTH; i++)
			ev.send(i[7:0], 3'b000);
		rchk(`ULS_OFS_LCOND, 8'h9f, 8'h03);
		for (i = 0; i < `ULS_QDEPTH; i++)
		begin
			acc(1'b0, `ULS_OFS_BUF, 8'h00);
			chk("rx", i[7:0], rx_data_out);
		end
		rchk(`ULS_OFS_LCOND, 8'h9f, 8'h00);
		// second reset in mid-run: store and identity back to their idle values
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		rchk(`ULS_OFS_STORE, 8'hff, `ULS_STORE_RESET);
		rchk(`ULS_OFS_IDENT, 8'hff, 8'hc1);
		end_of_test();
	end
endmodule
`default_nettype wire

// ==== test/uls_line_status_sva.sv ====
// port-level checks for the line status block
// assumes one clock domain and the offsets of uls_consts.svh
`include "uls_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module uls_line_status_sva
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire uls_pkg::uls_bus_t bus,
	input wire logic queue_mode_enable,
	input wire logic [1:0] trigger_sel,
	input wire logic rx_char_valid,
	input wire uls_pkg::uls_rx_char_t rx_char,
	input wire logic rx_break_end,
	input wire logic char_time_tick,
	input wire logic tx_load_shifter,
	input wire logic tx_shifter_busy,
	input wire logic [3:0] modem_change,
	input wire logic [7:0] rdata,
	input wire logic irq_output,
	input wire logic [7:0] rx_data_out
);
	logic [3:0] mask_sh_r;
	logic rd_go;
	logic wr_go;
	assign rd_go = bus.cs && bus.rd && clk_en;
	assign wr_go = bus.cs && bus.wr && clk_en;
	// shadow of the enable bits, upper ones never stored
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			mask_sh_r <= 4'h0;
		else if (wr_go && bus.addr == `ULS_OFS_MASK)
			mask_sh_r <= bus.wdata[3:0];
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	a_mask_readback:
	assert property (rd_go && bus.addr == `ULS_OFS_MASK |=> rdata == {4'h0, $past(mask_sh_r)}) else $error("mask readback wrong");
	a_store_readback:
	assert property (wr_go && bus.addr == `ULS_OFS_STORE ##1 !wr_go ##1 rd_go && bus.addr == `ULS_OFS_STORE
		|=> rdata == $past(bus.wdata, 3)) else $error("store readback wrong");
	a_ident_top_bits:
	assert property (rd_go && bus.addr == `ULS_OFS_IDENT |=> rdata[7:4] == {{2{$past(queue_mode_enable)}}, 2'b00})
		else $error("identity top bits wrong");
	a_ident_code_legal:
	assert property (rd_go && bus.addr == `ULS_OFS_IDENT |=> rdata[3:0] inside {4'h1, 4'h6, 4'h4, 4'hc, 4'h2, 4'h0})
		else $error("identity code illegal");
	a_ident_no_timeout:
	assert property (rd_go && bus.addr == `ULS_OFS_IDENT && !queue_mode_enable |=> !rdata[3]) else $error("timeout in char mode");
	a_qerr_char_zero:
	assert property (rd_go && bus.addr == `ULS_OFS_LCOND && !queue_mode_enable |=> !rdata[7]) else $error("queue error in char mode");
	a_idle_while_busy:
	assert property (rd_go && bus.addr == `ULS_OFS_LCOND && tx_shifter_busy && $past(tx_shifter_busy) |=> !rdata[6])
		else $error("idle while shifter busy");
	a_irq_all_masked:
	assert property (mask_sh_r == 4'h0 && $past(mask_sh_r) == 4'h0 |-> !irq_output) else $error("irq while all masked");
	a_modem_irq_up:
	assert property ((mask_sh_r == 4'h8 && modem_change != 4'h0 && clk_en)[*3] |-> irq_output) else $error("modem irq missing");
endmodule
bind uls_line_status uls_line_status_sva chk (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .bus(bus),
	.queue_mode_enable(queue_mode_enable), .trigger_sel(trigger_sel), .rx_char_valid(rx_char_valid),
	.rx_char(rx_char), .rx_break_end(rx_break_end), .char_time_tick(char_time_tick),
	.tx_load_shifter(tx_load_shifter), .tx_shifter_busy(tx_shifter_busy), .modem_change(modem_change),
	.rdata(rdata), .irq_output(irq_output), .rx_data_out(rx_data_out));
`default_nettype wire
